/* File: cable_regs_monitor.sv */
// Port checker of the PHY mode and cable test registers
`timescale 1ns/10ps
module cable_regs_monitor #(
   parameter [31:0] BREAK_BASE_CYC = 32'd8
) (
   // Clock and reset
   input wire       core_clk_in,
   input wire       nrst_in,
   // Observed ports
   input wire       mgmt_req_in,
   input wire [4:0] mgmt_station_in,
   input wire       mgmt_ack_out,
   input wire [4:0] station_id_out,
   input wire [4:0] scrambler_seed_out,
   input wire       line_break_out,
   input wire       test_tx_active_out,
   input wire [5:0] test_pattern_out,
   input wire       result_valid_in,
   input wire       power_down_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   reg [31:0] brk_q;
   // Counts cycles of the current line break
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) brk_q <= 32'h0;
      else brk_q <= line_break_out ? brk_q + 32'h1 : 32'h0;
   end
   a_ack_own_station: assert property (mgmt_req_in && mgmt_station_in == station_id_out |=> mgmt_ack_out)
      else $error("no ack after request to own station");
   a_no_foreign_ack: assert property (!(mgmt_req_in && mgmt_station_in == station_id_out) |=> !mgmt_ack_out)
      else $error("ack without request to own station");
   a_seed_tracks_id: assert property (scrambler_seed_out == station_id_out)
      else $error("scrambler seed differs from station id");
   a_break_then_tx: assert property ($rose(test_tx_active_out) |-> $past(line_break_out))
      else $error("patterns started without a preceding break");
   a_break_min_len: assert property ($rose(test_tx_active_out) |-> brk_q >= BREAK_BASE_CYC)
      else $error("line break shorter than base time");
   a_no_overlap: assert property (!(line_break_out && test_tx_active_out))
      else $error("break and patterns at once");
   a_idle_pattern: assert property (!test_tx_active_out |-> test_pattern_out == 6'h00)
      else $error("pattern driven outside test");
   a_result_ends_tx: assert property (test_tx_active_out && result_valid_in |=> !test_tx_active_out [*2])
      else $error("patterns continue after result");
   c_test_start: cover property ($rose(test_tx_active_out));
   c_foreign: cover property (mgmt_req_in && mgmt_station_in != station_id_out);
   c_power_down: cover property ($rose(power_down_out));
endmodule // cable_regs_monitor

bind phy_mode_and_cable_test_regs cable_regs_monitor #(.BREAK_BASE_CYC(BREAK_BASE_CYC)) mon (
   .core_clk_in(core_clk_in), .nrst_in(nrst_in), .mgmt_req_in(mgmt_req_in),
   .mgmt_station_in(mgmt_station_in), .mgmt_ack_out(mgmt_ack_out),
   .station_id_out(station_id_out), .scrambler_seed_out(scrambler_seed_out),
   .line_break_out(line_break_out), .test_tx_active_out(test_tx_active_out),
   .test_pattern_out(test_pattern_out), .result_valid_in(result_valid_in),
   .power_down_out(power_down_out));

/* File: mgmt_host_model.sv */
// Management host model issuing register accesses to one PHY
`timescale 1ns/10ps
module mgmt_host_model (
   // Clock
   input  wire        core_clk_in,
   // Requests towards the PHY
   output reg         mgmt_req_out,
   output reg         mgmt_write_out,
   output reg  [4:0]  mgmt_station_out,
   output reg  [4:0]  mgmt_index_out,
   output reg  [15:0] mgmt_wdata_out,
   // Answers from the PHY
   input  wire        mgmt_ack_in,
   input  wire [15:0] mgmt_rdata_in
);
   // Idle lines at time zero
   initial begin
      mgmt_req_out = 1'b0;
      mgmt_write_out = 1'b0;
      mgmt_station_out = 5'h1F;
      mgmt_index_out = 5'h1F;
      mgmt_wdata_out = 16'hFFFF;
   end
   // One access: request for one edge, then a bounded wait for the answer
   task access(input w, input [4:0] st, input [4:0] idx, input [15:0] wd,
               output [15:0] rd, output got);
      integer n;
      begin
         got = 1'b0;
         rd = 16'h0000;
         @(posedge core_clk_in);
         #1;
         mgmt_req_out = 1'b1;
         mgmt_write_out = w;
         mgmt_station_out = st; // Caller keeps station ids distinct
         mgmt_index_out = idx;
         mgmt_wdata_out = wd;
         @(posedge core_clk_in);
         #1;
         mgmt_req_out = 1'b0;
         mgmt_write_out = ~w;
         mgmt_station_out = ~st;
         mgmt_index_out = ~idx;
         mgmt_wdata_out = ~wd;
         for (n = 0; n < 3 && !got; n = n + 1) begin
            if (mgmt_ack_in === 1'b1) begin
               got = 1'b1;
               rd = mgmt_rdata_in;
            end else begin
               @(posedge core_clk_in);
               #1;
            end
         end
      end
   endtask
endmodule // mgmt_host_model

/* File: phy_mode_and_cable_test_regs.v */
// Mode select and cable test registers of one PHY with the cable test sequencer
`timescale 1ns/10ps
`include "phy_mode_tdr_defines.vh"

module phy_mode_and_cable_test_regs #(
   parameter        SAMPLE_W       = 10,
   parameter [31:0] BREAK_BASE_CYC = `BREAK_BASE_US * `CLK_MHZ,
   parameter [31:0] BREAK_STEP_CYC = `BREAK_STEP_MS * 1000 * `CLK_MHZ
) (
   // Clock and reset
   input  wire                core_clk_in,
   input  wire                nrst_in,
   // Configuration straps of this PHY
   input  wire                fiber_enable_strap_in,
   input  wire                autoneg_strap_in,
   input  wire                speed_strap_in,
   input  wire                duplex_strap_in,
   input  wire [4:0]          station_id_strap_in,
   // PHY soft reset from the chip reset control register
   input  wire                phy_reset_pulse_in,
   input  wire                phy_soft_reset_bit_in,
   // Management access
   input  wire                mgmt_req_in,
   input  wire                mgmt_write_in,
   input  wire [4:0]          mgmt_station_in,
   input  wire [4:0]          mgmt_index_in,
   input  wire [15:0]         mgmt_wdata_in,
   output reg                 mgmt_ack_out,
   output reg  [15:0]         mgmt_rdata_out,
   // Operating mode decode
   output reg                 fiber_mode_out,
   output reg                 speed_100_out,
   output reg                 full_duplex_out,
   output reg                 autoneg_en_out,
   output reg                 advertise_100fd_only_out,
   output reg                 crs_on_transmit_out,
   output reg                 power_down_out,
   output reg  [4:0]          station_id_out,
   output reg  [4:0]          scrambler_seed_out,
   // Cable test line side
   output reg                 line_break_out,
   output reg                 test_tx_active_out,
   output reg  [5:0]          test_pattern_out,
   input  wire                sample_valid_in,
   input  wire [SAMPLE_W-1:0] sample_in,
   output wire                filt_valid_out,
   output wire [SAMPLE_W-1:0] filt_sample_out,
   input  wire                result_valid_in,
   input  wire [1:0]          result_type_in,
   input  wire [7:0]          result_distance_in
);

   // Sequencer states
   localparam [3:0] ST_IDLE  = 4'h1;
   localparam [3:0] ST_BASE  = 4'h2;
   localparam [3:0] ST_STEP  = 4'h4;
   localparam [3:0] ST_PULSE = 4'h8;

   // Register state
   reg        strap_load_q;
   reg        fiber_q;
   reg [2:0]  mode_q;
   reg [4:0]  station_id_q;
   reg        delay_sel_q;
   reg [2:0]  break_cnt_q;
   reg [5:0]  pat_high_q;
   reg [5:0]  pat_low_q;
   reg        test_en_q;
   reg        filter_en_q;
   reg [1:0]  cable_type_q;
   reg        done_q;
   reg [7:0]  distance_q;
   reg [3:0]  state_q;
   reg [3:0]  state_d;
   reg [31:0] timer_q;
   reg [2:0]  steps_q;
   reg        phase_q;

   // Access decode
   wire       soft_reset_sensitive_class_reload;
   wire       access;
   wire       wr_sos;
   wire       wr_pd;
   wire       wr_cr;
   wire       start_req;
   wire       stop_req;
   wire       base_done;
   wire       step_done;
   wire       test_end;

   // Strap-derived operating mode
   function [2:0] mode_default;
      input fiber;
      input autoneg;
      input speed;
      input duplex;
      begin
         if (fiber)
            mode_default = duplex ? `MODE_100_FULL : `MODE_100_HALF;
         else if (autoneg)
            mode_default = `MODE_AN_ALL;
         else
            mode_default = {1'b0, speed, duplex};
      end
   endfunction

   // Register word assembly for reads, reserved bits as zero
   function [15:0] read_word;
      input [4:0] index;
      begin
         case (index)
            `REG_SPECIAL_OPERATING_SELECT:
               read_word = {5'h00, fiber_q, 2'h0, mode_q, station_id_q};
            `REG_CABLE_TEST_PATTERN_DELAY:
               read_word = {delay_sel_q, break_cnt_q, pat_high_q, pat_low_q};
            `REG_CABLE_TEST_CONTROL_RESULT:
               read_word = {test_en_q, filter_en_q, 3'h0, cable_type_q, done_q,
                            distance_q};
            default:
               read_word = 16'h0000;
         endcase
      end
   endfunction

   // Soft reset only acts on the sensitive class when the soft reset bit is set
   assign soft_reset_sensitive_class_reload = phy_reset_pulse_in & phy_soft_reset_bit_in;
   // Station match; no uniqueness check against other PHY addresses
   assign access      = mgmt_req_in & (mgmt_station_in == station_id_q);
   assign wr_sos      = access & mgmt_write_in &
                        (mgmt_index_in == `REG_SPECIAL_OPERATING_SELECT);
   assign wr_pd       = access & mgmt_write_in &
                        (mgmt_index_in == `REG_CABLE_TEST_PATTERN_DELAY);
   assign wr_cr       = access & mgmt_write_in &
                        (mgmt_index_in == `REG_CABLE_TEST_CONTROL_RESULT);
   assign start_req   = wr_cr & mgmt_wdata_in[`CR_ENABLE_BIT] & (state_q == ST_IDLE);
   assign stop_req    = (wr_cr & ~mgmt_wdata_in[`CR_ENABLE_BIT]) | soft_reset_sensitive_class_reload;
   assign base_done   = (timer_q == BREAK_BASE_CYC - 32'h0000_0001);
   assign step_done   = (timer_q == BREAK_STEP_CYC - 32'h0000_0001);
   assign test_end    = (state_q == ST_PULSE) & result_valid_in;

   // Sequencer next state
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (start_req)
               state_d = ST_BASE;
         ST_BASE:
            if (stop_req)
               state_d = ST_IDLE;
            else if (base_done)
               state_d = (delay_sel_q && steps_q != 3'h0) ? ST_STEP : ST_PULSE;
         ST_STEP:
            if (stop_req)
               state_d = ST_IDLE;
            else if (step_done && steps_q == 3'h1)
               state_d = ST_PULSE;
         ST_PULSE:
            if (stop_req || result_valid_in)
               state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // Sequencer state, break timing and pattern phase
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         timer_q <= 32'h0000_0000;
         steps_q <= 3'h0;
         phase_q <= 1'b0;
      end else begin
         state_q <= state_d;
         case (state_q)
            ST_IDLE: begin
               timer_q <= 32'h0000_0000;
               steps_q <= break_cnt_q;
               phase_q <= 1'b0;
            end
            ST_BASE: timer_q <= base_done ? 32'h0000_0000 : timer_q + 32'h0000_0001;
            ST_STEP: begin
               if (step_done) begin
                  timer_q <= 32'h0000_0000;
                  steps_q <= steps_q - 3'h1;
               end else begin
                  timer_q <= timer_q + 32'h0000_0001;
               end
            end
            ST_PULSE: phase_q <= ~phase_q;
            default:  timer_q <= 32'h0000_0000;
         endcase
      end
   end

   // Line side outputs, patterns only after the break ends
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         line_break_out     <= 1'b0;
         test_tx_active_out <= 1'b0;
         test_pattern_out   <= 6'h00;
      end else begin
         line_break_out     <= (state_d == ST_BASE) | (state_d == ST_STEP);
         test_tx_active_out <= (state_d == ST_PULSE);
         if (state_d == ST_PULSE)
            test_pattern_out <= (phase_q ^ (state_q == ST_PULSE)) ? pat_low_q : pat_high_q;
         else
            test_pattern_out <= 6'h00;
      end
   end

   // Operating select register with strap capture after reset release
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         strap_load_q <= 1'b1;
         fiber_q      <= 1'b0;
         mode_q       <= 3'h0;
         station_id_q <= 5'h00;
      end else if (strap_load_q) begin
         strap_load_q <= 1'b0;
         fiber_q      <= fiber_enable_strap_in;
         mode_q       <= mode_default(fiber_enable_strap_in, autoneg_strap_in,
                                      speed_strap_in, duplex_strap_in);
         station_id_q <= station_id_strap_in;
      end else if (soft_reset_sensitive_class_reload) begin
         fiber_q      <= fiber_enable_strap_in;
         station_id_q <= station_id_strap_in;
      end else if (wr_sos) begin
         fiber_q      <= mgmt_wdata_in[`SOS_FIBER_BIT];
         mode_q       <= mgmt_wdata_in[`SOS_MODE_HI:`SOS_MODE_LO];
         station_id_q <= mgmt_wdata_in[`SOS_ID_HI:`SOS_ID_LO];
      end
   end

   // Pattern and delay register
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         delay_sel_q <= `RST_DELAY_SEL;
         break_cnt_q <= `RST_BREAK_CNT;
         pat_high_q  <= `RST_PAT_HIGH;
         pat_low_q   <= `RST_PAT_LOW;
      end else if (soft_reset_sensitive_class_reload) begin
         delay_sel_q <= `RST_DELAY_SEL;
         break_cnt_q <= `RST_BREAK_CNT;
         pat_high_q  <= `RST_PAT_HIGH;
         pat_low_q   <= `RST_PAT_LOW;
      end else if (wr_pd) begin
         delay_sel_q <= mgmt_wdata_in[`PD_DELAY_SEL_BIT];
         break_cnt_q <= mgmt_wdata_in[`PD_BREAK_CNT_HI:`PD_BREAK_CNT_LO];
         pat_high_q  <= mgmt_wdata_in[`PD_PAT_HIGH_HI:`PD_PAT_HIGH_LO];
         pat_low_q   <= mgmt_wdata_in[`PD_PAT_LOW_HI:`PD_PAT_LOW_LO];
      end
   end

   // Control and result register; completion wins over a clearing stop or soft reset
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         test_en_q    <= 1'b0;
         filter_en_q  <= 1'b0;
         cable_type_q <= `RST_CABLE_TYPE;
         done_q       <= 1'b0;
         distance_q   <= `RST_DISTANCE;
      end else begin
         if (wr_cr)
            filter_en_q <= mgmt_wdata_in[`CR_FILTER_BIT];
         if (test_end) begin
            test_en_q    <= 1'b0;
            done_q       <= 1'b1;
            cable_type_q <= result_type_in;
            distance_q   <= result_distance_in;
         end else begin
            if (soft_reset_sensitive_class_reload)
               test_en_q <= 1'b0;
            else if (wr_cr && state_q == ST_IDLE)
               test_en_q <= mgmt_wdata_in[`CR_ENABLE_BIT];
            else if (stop_req)
               test_en_q <= 1'b0;
            if (start_req)
               done_q <= 1'b0;
         end
      end
   end

   // Management answer one cycle after a matching request
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mgmt_ack_out   <= 1'b0;
         mgmt_rdata_out <= 16'h0000;
      end else begin
         mgmt_ack_out <= access;
         if (access && !mgmt_write_in)
            mgmt_rdata_out <= read_word(mgmt_index_in);
      end
   end

   // Mode decode to the PHY core
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fiber_mode_out           <= 1'b0;
         {speed_100_out, full_duplex_out, autoneg_en_out} <= 3'h0;
         {advertise_100fd_only_out, crs_on_transmit_out, power_down_out} <= 3'h0;
         station_id_out           <= 5'h00;
         scrambler_seed_out       <= 5'h00;
      end else begin
         fiber_mode_out     <= fiber_q;
         station_id_out     <= station_id_q;
         scrambler_seed_out <= station_id_q;
         {speed_100_out, full_duplex_out, autoneg_en_out} <= 3'h0;
         {advertise_100fd_only_out, crs_on_transmit_out, power_down_out} <= 3'h0;
         case (mode_q)
            `MODE_10_HALF: crs_on_transmit_out <= 1'b1;
            `MODE_10_FULL: full_duplex_out <= 1'b1;
            `MODE_100_HALF: begin
               speed_100_out       <= 1'b1;
               crs_on_transmit_out <= 1'b1;
            end
            `MODE_100_FULL: begin
               speed_100_out   <= 1'b1;
               full_duplex_out <= 1'b1;
            end
            `MODE_AN_100_FULL: begin
               autoneg_en_out           <= 1'b1;
               advertise_100fd_only_out <= 1'b1;
               speed_100_out            <= 1'b1;
               full_duplex_out          <= 1'b1;
            end
            `MODE_POWER_DOWN: power_down_out <= 1'b1;
            `MODE_AN_ALL: autoneg_en_out <= 1'b1;
            default: power_down_out <= 1'b0; // Reserved code leaves all decodes low
         endcase
      end
   end

   // Reflection sample filter, cleared at each test start
   reflection_filter #(.SAMPLE_W (SAMPLE_W)) u_filter (
      .core_clk_in     (core_clk_in),
      .nrst_in         (nrst_in),
      .filter_en_in    (filter_en_q),
      .clear_in        (start_req),
      .sample_valid_in (sample_valid_in),
      .sample_in       (sample_in),
      .filt_valid_out  (filt_valid_out),
      .filt_sample_out (filt_sample_out)
   );

endmodule // phy_mode_and_cable_test_regs

/* File: phy_mode_and_cable_test_regs_test.sv */
// Self-checking bench of the PHY mode and cable test registers
`timescale 1ns/10ps
`include "phy_mode_tdr_defines.vh"
module phy_mode_and_cable_test_regs_test;
   localparam [31:0] BASE = 32'd8;
   localparam [31:0] STEP = 32'd16;
   reg        core_clk_in, nrst_in, fib_s, an_s, spd_s, dpx_s, rst_p, soft_b, smp_v, res_v;
   reg  [4:0] id_s, my_id;
   reg  [9:0] smp;
   reg  [1:0] res_t;
   reg  [7:0] res_d;
   reg [15:0] rd;
   reg        got;
   reg [31:0] brk_n;
   wire       req, wr, ack, fib, spd, fdx, an, adv, crs, pdn, lbrk, tx, fv;
   wire [4:0] st, idx, id, seed;
   wire [15:0] wd, rdata;
   wire [5:0] pat;
   wire [9:0] fs;
   integer    num_errors, n_checks;
   mgmt_host_model host (.core_clk_in(core_clk_in), .mgmt_req_out(req), .mgmt_write_out(wr),
      .mgmt_station_out(st), .mgmt_index_out(idx), .mgmt_wdata_out(wd),
      .mgmt_ack_in(ack), .mgmt_rdata_in(rdata));
   phy_mode_and_cable_test_regs #(.BREAK_BASE_CYC(BASE), .BREAK_STEP_CYC(STEP)) DUT (
      .core_clk_in(core_clk_in), .nrst_in(nrst_in), .fiber_enable_strap_in(fib_s),
      .autoneg_strap_in(an_s), .speed_strap_in(spd_s), .duplex_strap_in(dpx_s),
      .station_id_strap_in(id_s), .phy_reset_pulse_in(rst_p), .phy_soft_reset_bit_in(soft_b),
      .mgmt_req_in(req), .mgmt_write_in(wr), .mgmt_station_in(st), .mgmt_index_in(idx),
      .mgmt_wdata_in(wd), .mgmt_ack_out(ack), .mgmt_rdata_out(rdata), .fiber_mode_out(fib),
      .speed_100_out(spd), .full_duplex_out(fdx), .autoneg_en_out(an),
      .advertise_100fd_only_out(adv), .crs_on_transmit_out(crs), .power_down_out(pdn),
      .station_id_out(id), .scrambler_seed_out(seed), .line_break_out(lbrk),
      .test_tx_active_out(tx), .test_pattern_out(pat), .sample_valid_in(smp_v),
      .sample_in(smp), .filt_valid_out(fv), .filt_sample_out(fs), .result_valid_in(res_v),
      .result_type_in(res_t), .result_distance_in(res_d));
   // Clock and break length counter
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) brk_n <= lbrk ? brk_n + 32'h1 : (tx ? brk_n : 32'h0);
   task cmp(input [15:0] a, input [15:0] e, input [8*10-1:0] what);
      begin
         n_checks = n_checks + 1;
         if (a !== e) begin
            num_errors = num_errors + 1;
            $display("BAD %0t %0s got %h want %h", $time, what, a, e);
         end
      end
   endtask
   task rd_reg(input [4:0] i, input [15:0] e, input [8*10-1:0] what);
      begin
         host.access(1'b0, my_id, i, 16'h0000, rd, got);
         cmp({15'h0, got}, 16'h0001, "ack");
         cmp(rd, e, what);
      end
   endtask
   task wr_reg(input [4:0] i, input [15:0] v);
      host.access(1'b1, my_id, i, v, rd, got);
   endtask
   task do_reset(input f, input a, input s, input d);
      begin
         @(posedge core_clk_in);
         #1 nrst_in = 1'b0;
         {fib_s, an_s, spd_s, dpx_s} = {f, a, s, d};
         my_id = id_s;
         repeat (2) @(posedge core_clk_in);
         #1 nrst_in = 1'b1;
         repeat (2) @(posedge core_clk_in);
      end
   endtask
   task t_straps;
      integer i;
      reg [3:0] s;
      reg [2:0] m;
      for (i = 0; i < 16; i = i + 1) begin
         s = i[3:0];
         do_reset(s[3], s[2], s[1], s[0]);
         m = s[3] ? {2'b01, s[0]} : (s[2] ? 3'h7 : {1'b0, s[1], s[0]});
         rd_reg(`REG_SPECIAL_OPERATING_SELECT, {5'h0, s[3], 2'h0, m, id_s}, "strap");
         cmp({15'h0, fib}, {15'h0, s[3]}, "fiber");
      end
   endtask
   task t_modes;
      integer c;
      reg [5:0] e, k;
      for (c = 0; c < 8; c = c + 1) begin
         wr_reg(`REG_SPECIAL_OPERATING_SELECT, {5'h1F, 1'b0, 2'h3, c[2:0], my_id});
         rd_reg(`REG_SPECIAL_OPERATING_SELECT, {8'h0, c[2:0], my_id}, "mode");
         repeat (2) @(posedge core_clk_in);
         #1;
         case (c)
            0: {e, k} = {6'h08, 6'h3F};
            1: {e, k} = {6'h01, 6'h3F};
            2: {e, k} = {6'h0A, 6'h3F};
            3: {e, k} = {6'h03, 6'h3F};
            4: {e, k} = {6'h30, 6'h3C};
            5: {e, k} = {6'h00, 6'h3F};
            6: {e, k} = {6'h04, 6'h34};
            default: {e, k} = {6'h20, 6'h34};
         endcase
         cmp({10'h0, {an, adv, crs, pdn, spd, fdx} & k}, {10'h0, e & k}, "decode");
      end
   endtask
   task t_soft_reset(input b, input [15:0] e);
      begin
         wr_reg(`REG_CABLE_TEST_PATTERN_DELAY, 16'h1234);
         {rst_p, soft_b} = {1'b1, b};
         @(posedge core_clk_in);
         #1 rst_p = 1'b0;
         rd_reg(`REG_CABLE_TEST_PATTERN_DELAY, e, "soft rst");
      end
   endtask
   task t_station;
      begin
         wr_reg(`REG_SPECIAL_OPERATING_SELECT, {8'h0, 3'h7, 5'h0A});
         host.access(1'b0, my_id, `REG_SPECIAL_OPERATING_SELECT, 16'h0, rd, got);
         cmp({15'h0, got}, 16'h0000, "old id");
         my_id = 5'h0A;
         rd_reg(`REG_SPECIAL_OPERATING_SELECT, 16'h00EA, "new id");
         cmp({11'h0, seed}, 16'h000A, "seed");
      end
   endtask
   task run_test(input ds, input [2:0] cn, input [1:0] ty, input [7:0] di);
      integer n;
      begin
         wr_reg(`REG_CABLE_TEST_PATTERN_DELAY, {ds, cn, 6'h2A, 6'h15});
         wr_reg(`REG_CABLE_TEST_CONTROL_RESULT, 16'hC000);
         rd_reg(`REG_CABLE_TEST_CONTROL_RESULT, {5'h18, ~res_t, 1'b0, ~res_d},
                "running");
         for (n = 0; n < 200 && !tx; n = n + 1) @(posedge core_clk_in) #1;
         cmp(brk_n[15:0], (ds && cn != 3'h0) ? BASE + cn * STEP : BASE, "break");
         cmp({10'h0, pat}, 16'h002A, "pat high");
         @(posedge core_clk_in);
         #1 {res_v, res_t, res_d} = {1'b1, ty, di};
         cmp({10'h0, pat}, 16'h0015, "pat low");
         @(posedge core_clk_in);
         #1 {res_v, res_t, res_d} = {1'b0, ~ty, ~di};
         cmp({15'h0, tx}, 16'h0000, "tx end");
         rd_reg(`REG_CABLE_TEST_CONTROL_RESULT, {5'h08, ty, 1'b1, di}, "result");
      end
   endtask
   task feed(input [9:0] v, input [9:0] e);
      begin
         #8 {smp_v, smp} = {1'b1, v};
         @(posedge core_clk_in);
         #1 {smp_v, smp} = {1'b0, ~v};
         cmp({5'h0, fv, fs}, {6'h01, e}, "filter");
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   // Watchdog
   initial begin
      #400000;
      num_errors = num_errors + 1;
      print_verdict;
   end
   // Main sequence
   initial begin
      {nrst_in, fib_s, an_s, spd_s, dpx_s, rst_p, soft_b, smp_v, res_v} = 9'h0;
      {id_s, my_id, smp, res_t, res_d, brk_n} = {5'h03, 5'h03, 10'h0, 2'h3, 8'hFF, 32'h0};
      num_errors = 0;
      n_checks = 0;
      t_straps;
      do_reset(1'b0, 1'b1, 1'b0, 1'b0);
      rd_reg(`REG_CABLE_TEST_PATTERN_DELAY, 16'h9B9D, "rst pd");
      rd_reg(`REG_CABLE_TEST_CONTROL_RESULT, 16'h0000, "rst cr");
      rd_reg(5'h05, 16'h0000, "unmapped");
      t_modes;
      t_soft_reset(1'b0, 16'h1234);
      t_soft_reset(1'b1, 16'h9B9D);
      my_id = id_s;
      t_station;
      run_test(1'b1, 3'h2, 2'h2, 8'h55);
      run_test(1'b0, 3'h5, 2'h1, 8'hA3);
      run_test(1'b1, 3'h0, 2'h3, 8'h00);
      run_test(1'b1, 3'h7, 2'h0, 8'h07);
      feed(10'd10, 10'd0);
      feed(10'd10, 10'd10);
      feed(10'd500, 10'd10);
      wr_reg(`REG_CABLE_TEST_CONTROL_RESULT, 16'h0000);
      feed(10'd300, 10'd300);
      print_verdict;
   end
endmodule // phy_mode_and_cable_test_regs_test

/* File: phy_mode_tdr_defines.vh */
// Offsets, field positions, reset values and timing figures of the PHY mode and cable test registers
`ifndef PHY_MODE_TDR_DEFINES_VH
`define PHY_MODE_TDR_DEFINES_VH

// Register indices on the management interface
`define REG_SPECIAL_OPERATING_SELECT 5'h12
`define REG_CABLE_TEST_PATTERN_DELAY 5'h18
`define REG_CABLE_TEST_CONTROL_RESULT 5'h19

// Operating select fields
`define SOS_FIBER_BIT      10
`define SOS_MODE_HI        7
`define SOS_MODE_LO        5
`define SOS_ID_HI          4
`define SOS_ID_LO          0

// Pattern and delay fields
`define PD_DELAY_SEL_BIT   15
`define PD_BREAK_CNT_HI    14
`define PD_BREAK_CNT_LO    12
`define PD_PAT_HIGH_HI     11
`define PD_PAT_HIGH_LO     6
`define PD_PAT_LOW_HI      5
`define PD_PAT_LOW_LO      0

// Control and result fields
`define CR_ENABLE_BIT      15
`define CR_FILTER_BIT      14
`define CR_TYPE_HI         10
`define CR_TYPE_LO         9
`define CR_DONE_BIT        8
`define CR_DIST_HI         7
`define CR_DIST_LO         0

// Reset values
`define RST_DELAY_SEL      1'b1
`define RST_BREAK_CNT      3'h1
`define RST_PAT_HIGH       6'h2E
`define RST_PAT_LOW        6'h1D
`define RST_CABLE_TYPE     2'h0
`define RST_DISTANCE       8'h00

// Operating mode codes
`define MODE_10_HALF       3'h0
`define MODE_10_FULL       3'h1
`define MODE_100_HALF      3'h2
`define MODE_100_FULL      3'h3
`define MODE_AN_100_FULL   3'h4
`define MODE_RESERVED      3'h5
`define MODE_POWER_DOWN    3'h6
`define MODE_AN_ALL        3'h7

// Cable type codes
`define CABLE_DEFAULT      2'h0
`define CABLE_SHORTED      2'h1
`define CABLE_OPEN         2'h2
`define CABLE_MATCHED      2'h3

// Timing figures
`define CLK_MHZ            125
`define BREAK_BASE_US      2000
`define BREAK_STEP_MS      256

`endif

/* File: reflection_filter.v */
// Spike filter for converted reflection samples of the cable test
`timescale 1ns/10ps

module reflection_filter #(
   parameter SAMPLE_W = 10
) (
   // Clock and reset
   input  wire                core_clk_in,
   input  wire                nrst_in,
   // Control
   input  wire                filter_en_in,
   input  wire                clear_in,
   // Raw samples
   input  wire                sample_valid_in,
   input  wire [SAMPLE_W-1:0] sample_in,
   // Filtered samples
   output reg                 filt_valid_out,
   output reg  [SAMPLE_W-1:0] filt_sample_out
);

   reg [SAMPLE_W-1:0] tap1_q;
   reg [SAMPLE_W-1:0] tap2_q;

   // Median of three rejects a single-sample spike
   function [SAMPLE_W-1:0] median3;
      input [SAMPLE_W-1:0] a;
      input [SAMPLE_W-1:0] b;
      input [SAMPLE_W-1:0] c;
      begin
         if ((a >= b && a <= c) || (a <= b && a >= c))
            median3 = a;
         else if ((b >= a && b <= c) || (b <= a && b >= c))
            median3 = b;
         else
            median3 = c;
      end
   endfunction

   // Sample history and registered output
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tap1_q          <= {SAMPLE_W{1'b0}};
         tap2_q          <= {SAMPLE_W{1'b0}};
         filt_valid_out  <= 1'b0;
         filt_sample_out <= {SAMPLE_W{1'b0}};
      end else if (clear_in) begin
         tap1_q          <= {SAMPLE_W{1'b0}};
         tap2_q          <= {SAMPLE_W{1'b0}};
         filt_valid_out  <= 1'b0;
         filt_sample_out <= {SAMPLE_W{1'b0}};
      end else begin
         filt_valid_out <= sample_valid_in;
         if (sample_valid_in) begin
            tap1_q <= sample_in;
            tap2_q <= tap1_q;
            if (filter_en_in)
               filt_sample_out <= median3(sample_in, tap1_q, tap2_q);
            else
               filt_sample_out <= sample_in;
         end
      end
   end

endmodule // reflection_filter
